// ---- mlm_defs.vh ----
`ifndef MLM_DEFS_VH
`define MLM_DEFS_VH

// Register offsets
`define MLM_ADDR_VAL0    8'h20
`define MLM_ADDR_LTEMP   8'h27
`define MLM_ADDR_LIM0    8'h2B
`define MLM_ADDR_LIMLAST 8'h3A
`define MLM_ADDR_CFG     8'h40
`define MLM_ADDR_ST1     8'h41
`define MLM_ADDR_ST2     8'h42

// Field positions
`define MLM_CFG_START    0
`define MLM_ST2_DFAULT   6

// Reset values
`define MLM_RST_BYTE     8'h00

// Channels
`define MLM_NCH          8
`define MLM_CH_REMOTE    3'h6
`define MLM_CH_LOCAL     3'h7
`define MLM_AVG_N        16
`define MLM_AVG_LAST     4'hF

// Timing
`define MLM_CLK_MHZ      200
`define MLM_T_CONV_US    11600
`define MLM_T_REMOTE_US  34800
`define MLM_CONV_CYC     (`MLM_T_CONV_US * `MLM_CLK_MHZ)
`define MLM_REM_SUB_CYC  ((`MLM_T_REMOTE_US * `MLM_CLK_MHZ) / `MLM_AVG_N)

`endif

// ---- mlm_avg16.v ----
`timescale 1ns/1ps
`include "mlm_defs.vh"

// Running sum of signed samples, divided by sixteen on the way out
module mlm_avg16 (
  input  wire              clk_i,
  input  wire              rst_i,
  input  wire              clr_i,
  input  wire              add_i,
  input  wire        [7:0] smp_i,
  output wire        [7:0] avg_o
);

  reg  signed [11:0] acc_q;
  wire signed [11:0] smp_ext;

  assign smp_ext = {{4{smp_i[7]}}, smp_i};

  // Clear has priority so a fresh measurement never inherits old samples
  always @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      acc_q <= 12'h000;
    end else if (add_i) begin
      acc_q <= acc_q + smp_ext;
    end
  end

  // Arithmetic shift truncates toward minus infinity
  assign avg_o = acc_q[11:4];

endmodule

// ---- mlm_lim.v ----
`timescale 1ns/1ps

// Window comparator; equality with a limit counts as inside
module mlm_lim (
  input  wire [7:0] val_i,
  input  wire [7:0] hi_i,
  input  wire [7:0] lo_i,
  input  wire       sgn_i,
  output wire       oor_o
);

  wire above_s;
  wire below_s;
  wire above_u;
  wire below_u;

  assign above_s = $signed(val_i) > $signed(hi_i);
  assign below_s = $signed(val_i) < $signed(lo_i);
  assign above_u = val_i > hi_i;
  assign below_u = val_i < lo_i;

  assign oor_o = sgn_i ? (above_s | below_s) : (above_u | below_u);

endmodule

// ---- mlm_loop.v ----
`timescale 1ns/1ps
`include "mlm_defs.vh"

module mlm_loop #(
  parameter [31:0] CONV_CYC    = `MLM_CONV_CYC,
  parameter [31:0] REM_SUB_CYC = `MLM_REM_SUB_CYC
) (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire [7:0] reg_addr_i,
  input  wire       reg_wr_i,
  input  wire [7:0] reg_wdata_i,
  input  wire       reg_rd_i,
  output reg  [7:0] reg_rdata_o,
  input  wire [7:0] adc_data_i,
  input  wire       adc_valid_i,
  input  wire       diode_fault_i,
  output reg        adc_start_o,
  output reg  [2:0] adc_chan_o,
  output reg  [7:0] status1_o,
  output reg  [7:0] status2_o,
  output reg        irq_o,
  output reg        low_power_o
);

  localparam [1:0] S_IDLE  = 2'b00;
  localparam [1:0] S_CONV  = 2'b01;
  localparam [1:0] S_STORE = 2'b10;
  localparam [1:0] S_CMP   = 2'b11;

  reg  [1:0]  state_q;
  reg  [31:0] cnt_q;
  reg  [3:0]  sub_q;
  reg  [7:0]  smp_q;
  reg  [7:0]  cfg_q;
  reg  [7:0]  val_q [0:`MLM_NCH-1];
  reg  [7:0]  hi_q  [0:`MLM_NCH-1];
  reg  [7:0]  lo_q  [0:`MLM_NCH-1];
  reg  [7:0]  rd_d;
  reg  [7:0]  st1_d;
  reg  [7:0]  st2_d;
  integer     i;
  integer     j;

  wire        start;
  wire        is_remote;
  wire [31:0] slot_len;
  wire        slot_end;
  wire        avg_add;
  wire        avg_clr;
  wire [7:0]  avg_val;
  wire        oor;
  wire        sgn;
  wire [7:0]  val_off;
  wire [7:0]  lim_off;
  wire        in_val;
  wire        in_lim;
  wire [2:0]  lim_ch;
  wire        st1_rd;
  wire [7:0]  cmp_val;
  wire [7:0]  cmp_hi;
  wire [7:0]  cmp_lo;
  wire        cmp_en;
  wire        fault_en;
  wire        irq_set;
  wire        irq_clr;

  assign start     = cfg_q[`MLM_CFG_START];
  assign is_remote = (adc_chan_o == `MLM_CH_REMOTE);
  // Remote slots are one sixteenth of the full averaged measurement
  assign slot_len  = is_remote ? REM_SUB_CYC : CONV_CYC;
  assign slot_end  = (state_q == S_CONV) && (cnt_q == slot_len - 32'd1);
  assign avg_add   = slot_end && is_remote;
  assign avg_clr   = (state_q == S_IDLE) ||
                     ((state_q == S_STORE) && (sub_q == `MLM_AVG_LAST));

  // Address decode for value and limit windows
  assign val_off = reg_addr_i - `MLM_ADDR_VAL0;
  assign lim_off = reg_addr_i - `MLM_ADDR_LIM0;
  assign in_val  = (reg_addr_i >= `MLM_ADDR_VAL0) &&
                   (reg_addr_i <= `MLM_ADDR_LTEMP);
  assign in_lim  = (reg_addr_i >= `MLM_ADDR_LIM0) &&
                   (reg_addr_i <= `MLM_ADDR_LIMLAST);
  assign lim_ch  = lim_off[3:1];
  assign st1_rd  = reg_rd_i && (reg_addr_i == `MLM_ADDR_ST1);

  // Temperature channels are the two highest indices
  assign sgn     = (adc_chan_o == `MLM_CH_REMOTE) ||
                   (adc_chan_o == `MLM_CH_LOCAL);
  assign cmp_val = val_q[adc_chan_o];
  assign cmp_hi  = hi_q[adc_chan_o];
  assign cmp_lo  = lo_q[adc_chan_o];

  // Update strobes; gated by start so an aborted slot leaves status alone
  assign cmp_en   = start && (state_q == S_CMP);
  assign fault_en = start && (state_q == S_STORE) && is_remote &&
                    (sub_q == `MLM_AVG_LAST);
  // Set beats clear, so an event in the read cycle is never lost
  assign irq_set  = cmp_en && oor;
  assign irq_clr  = st1_rd;

  mlm_avg16 u_avg (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .clr_i (avg_clr),
    .add_i (avg_add),
    .smp_i (adc_data_i),
    .avg_o (avg_val)
  );

  mlm_lim u_lim (
    .val_i (cmp_val),
    .hi_i  (cmp_hi),
    .lo_i  (cmp_lo),
    .sgn_i (sgn),
    .oor_o (oor)
  );

  // Host writes: configuration and limits; values and status are read only
  always @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q <= `MLM_RST_BYTE;
      for (i = 0; i < `MLM_NCH; i = i + 1) begin
        hi_q[i] <= `MLM_RST_BYTE;
        lo_q[i] <= `MLM_RST_BYTE;
      end
    end else if (reg_wr_i) begin
      if (reg_addr_i == `MLM_ADDR_CFG) begin
        cfg_q <= reg_wdata_i;
      end else if (in_lim) begin
        if (lim_off[0]) begin
          lo_q[lim_ch] <= reg_wdata_i;
        end else begin
          hi_q[lim_ch] <= reg_wdata_i;
        end
      end
    end
  end

  // Read mux; unmapped addresses return zero
  always @* begin
    rd_d = `MLM_RST_BYTE;
    if (in_val) begin
      rd_d = val_q[val_off[2:0]];
    end else if (in_lim) begin
      rd_d = lim_off[0] ? lo_q[lim_ch] : hi_q[lim_ch];
    end else begin
      case (reg_addr_i)
        `MLM_ADDR_CFG: rd_d = cfg_q;
        `MLM_ADDR_ST1: rd_d = status1_o;
        `MLM_ADDR_ST2: rd_d = status2_o;
        default:       rd_d = `MLM_RST_BYTE;
      endcase
    end
  end

  // Read data lands one cycle after the strobe, no side effect on status
  always @(posedge clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= `MLM_RST_BYTE;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_d;
    end
  end

  // Sample capture from the converter during a slot
  always @(posedge clk_i) begin
    if (rst_i) begin
      smp_q <= `MLM_RST_BYTE;
    end else if (adc_valid_i && state_q == S_CONV) begin
      smp_q <= adc_data_i;
    end
  end

  // Round-robin sequencer; dropping the start bit aborts the current slot
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q     <= S_IDLE;
      cnt_q       <= 32'h0000_0000;
      sub_q       <= 4'h0;
      adc_chan_o  <= 3'h0;
      adc_start_o <= 1'b0;
      low_power_o <= 1'b1;
      for (j = 0; j < `MLM_NCH; j = j + 1) begin
        val_q[j] <= `MLM_RST_BYTE;
      end
    end else begin
      adc_start_o <= 1'b0;
      low_power_o <= ~start;
      if (!start) begin
        state_q    <= S_IDLE;
        cnt_q      <= 32'h0000_0000;
        sub_q      <= 4'h0;
        adc_chan_o <= 3'h0;
      end else begin
        case (state_q)
          S_IDLE: begin
            state_q     <= S_CONV;
            cnt_q       <= 32'h0000_0000;
            adc_start_o <= 1'b1;
          end
          S_CONV: begin
            if (slot_end) begin
              state_q <= S_STORE;
            end else begin
              cnt_q <= cnt_q + 32'd1;
            end
          end
          S_STORE: begin
            cnt_q <= 32'h0000_0000;
            if (is_remote && sub_q != `MLM_AVG_LAST) begin
              // More sub-conversions still to accumulate
              sub_q       <= sub_q + 4'h1;
              state_q     <= S_CONV;
              adc_start_o <= 1'b1;
            end else begin
              sub_q   <= 4'h0;
              state_q <= S_CMP;
              if (is_remote) begin
                val_q[adc_chan_o] <= avg_val;
              end else begin
                val_q[adc_chan_o] <= smp_q;
              end
            end
          end
          S_CMP: begin
            // Fixed rotation, wraps after the last channel
            adc_chan_o  <= adc_chan_o + 3'h1;
            state_q     <= S_CONV;
            adc_start_o <= 1'b1;
          end
          default: begin
            state_q <= S_IDLE;
          end
        endcase
      end
    end
  end

  // Next status: only the channel just compared, or the fault bit, moves
  always @* begin
    st1_d = status1_o;
    st2_d = status2_o;
    if (fault_en) begin
      st2_d[`MLM_ST2_DFAULT] = diode_fault_i;
    end
    if (cmp_en) begin
      case (adc_chan_o)
        3'h0:    st1_d[0] = oor;
        3'h1:    st1_d[1] = oor;
        3'h2:    st1_d[2] = oor;
        3'h3:    st1_d[3] = oor;
        3'h4:    st2_d[0] = oor;
        3'h5:    st2_d[1] = oor;
        // Temperature bits sit apart from the voltage bits
        3'h6:    st1_d[5] = oor;
        3'h7:    st1_d[4] = oor;
        default: st1_d = status1_o;
      endcase
    end
  end

  // Status registers; host reads never write them, so polling is harmless
  always @(posedge clk_i) begin
    if (rst_i) begin
      status1_o <= `MLM_RST_BYTE;
      status2_o <= `MLM_RST_BYTE;
    end else begin
      status1_o <= st1_d;
      status2_o <= st2_d;
    end
  end

  // Sticky interrupt; a fresh out-of-limit result beats the clearing read
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else if (irq_set) begin
      irq_o <= 1'b1;
    end else if (irq_clr) begin
      irq_o <= 1'b0;
    end
  end

endmodule

// ---- mlm_loop_asserts.sv ----
`timescale 1ns/1ps
// Port-level checks for the monitoring loop
module mlm_loop_asserts #(
  parameter [31:0] CONV_CYC    = 20,
  parameter [31:0] REM_SUB_CYC = 8
) (
  input wire       clk_i,
  input wire       rst_i,
  input wire [7:0] reg_addr_i,
  input wire       reg_wr_i,
  input wire [7:0] reg_wdata_i,
  input wire       reg_rd_i,
  input wire [7:0] reg_rdata_o,
  input wire [7:0] adc_data_i,
  input wire       adc_valid_i,
  input wire       diode_fault_i,
  input wire       adc_start_o,
  input wire [2:0] adc_chan_o,
  input wire [7:0] status1_o,
  input wire [7:0] status2_o,
  input wire       irq_o,
  input wire       low_power_o
);
  localparam int SLOT = CONV_CYC + 2;
  localparam int SUB  = REM_SUB_CYC + 1;
  localparam int SUB2 = REM_SUB_CYC + 2;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_start_one_cycle: assert property (adc_start_o |=> !adc_start_o)
    else $error("start strobe longer than one cycle");
  a_halted_no_start: assert property (low_power_o |-> !adc_start_o)
    else $error("conversion started while halted");
  a_rdata_holds: assert property (
    !reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  a_spare_bits_zero: assert property (status1_o[7:6] == 2'h0
    && status2_o[7] == 1'b0 && status2_o[5:2] == 4'h0)
    else $error("unused status bit set");
  a_irq_has_cause: assert property ($rose(irq_o)
    |-> (status1_o[5:0] != 6'h00 || status2_o[1:0] != 2'h0))
    else $error("interrupt without out-of-limit status");
  a_irq_clear_read: assert property ($fell(irq_o)
    |-> $past(reg_rd_i && reg_addr_i == 8'h41))
    else $error("interrupt dropped without status read");
  a_start_bit_go: assert property (reg_wr_i && reg_addr_i == 8'h40
    && reg_wdata_i[0] |-> ##2 (adc_start_o && adc_chan_o == 3'h0))
    else $error("loop did not start at channel zero");
  a_start_bit_halt: assert property (reg_wr_i
    && reg_addr_i == 8'h40 && !reg_wdata_i[0] |-> ##2 low_power_o)
    else $error("loop did not halt");
  a_slot_rotation: assert property (adc_start_o
    && adc_chan_o != 3'h6 |-> ##SLOT (low_power_o || (adc_start_o
    && adc_chan_o == $past(adc_chan_o, SLOT) + 3'h1)))
    else $error("slot length or channel order wrong");
  a_remote_sub_slot: assert property (adc_start_o
    && adc_chan_o == 3'h6 |-> ##[SUB:SUB2] (adc_start_o || low_power_o))
    else $error("remote sub-slot length wrong");
endmodule

bind mlm_loop mlm_loop_asserts #(
  .CONV_CYC(CONV_CYC), .REM_SUB_CYC(REM_SUB_CYC)) i_mlm_loop_asserts (
  .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .adc_data_i(adc_data_i),
  .adc_valid_i(adc_valid_i), .diode_fault_i(diode_fault_i),
  .adc_start_o(adc_start_o), .adc_chan_o(adc_chan_o),
  .status1_o(status1_o), .status2_o(status2_o), .irq_o(irq_o),
  .low_power_o(low_power_o));

// ---- mlm_adc_model.sv ----
`timescale 1ns/1ps
// Converter and remote diode stand-in; sample held steady through the slot
module mlm_adc_model (
  input  wire       clk_i,
  input  wire       start_i,
  input  wire [2:0] chan_i,
  output reg  [7:0] data_o,
  output reg        valid_o,
  output reg        fault_o
);
  reg [7:0] smp [0:7];
  reg [3:0] k_q;
  integer   dly = 2;
  integer   cnt = 99;
  initial begin
    data_o = 8'h00;
    valid_o = 1'b0;
    fault_o = 1'b0;
    k_q = 4'hF;
  end
  // Stale data inverted at slot start so a missed sample shows up
  always @(posedge clk_i) begin
    cnt <= cnt + 1;
    valid_o <= (cnt + 1 == dly);
    if (start_i) begin
      data_o <= ~data_o;
      cnt <= 0;
      k_q <= (chan_i == 3'h6) ? k_q + 4'h1 : 4'hF;
    end else if (cnt == 0) begin
      // Remote samples spread -8..+7 round the base, signed
      data_o <= (chan_i == 3'h6) ? smp[6] + {4'h0, k_q} - 8'h08
                                 : smp[chan_i];
    end
  end
endmodule

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
  logic       clk_i;
  logic       rst_i;
  logic [7:0] reg_addr_i;
  logic       reg_wr_i;
  logic [7:0] reg_wdata_i;
  logic       reg_rd_i;
  wire  [7:0] reg_rdata_o;
  wire  [7:0] adc_data_i;
  wire        adc_valid_i;
  wire        diode_fault_i;
  wire        adc_start_o;
  wire  [2:0] adc_chan_o;
  wire  [7:0] status1_o;
  wire  [7:0] status2_o;
  wire        irq_o;
  wire        low_power_o;
  int         error_cnt = 0;
  int         comparisons = 0;
  int         cyc = 0;
  // Limits 60/40 on ch0..4 hit both edges; ch5 only passes unsigned
  logic [7:0] hi [8] = '{8'h3C, 8'h3C, 8'h3C, 8'h3C, 8'h3C, 8'hFA, 8'h00,
                         8'h00};
  logic [7:0] lo [8] = '{8'h28, 8'h28, 8'h28, 8'h28, 8'h28, 8'h64, 8'h80,
                         8'hCE};
  logic [7:0] sv [8] = '{8'h32, 8'h3C, 8'h28, 8'h3D, 8'h27, 8'hC8, 8'hF6,
                         8'hE7};

  mlm_loop #(.CONV_CYC(32'd20), .REM_SUB_CYC(32'd8)) i_mlm_loop (
    .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .adc_data_i(adc_data_i),
    .adc_valid_i(adc_valid_i), .diode_fault_i(diode_fault_i),
    .adc_start_o(adc_start_o), .adc_chan_o(adc_chan_o),
    .status1_o(status1_o), .status2_o(status2_o), .irq_o(irq_o),
    .low_power_o(low_power_o));
  mlm_adc_model i_mlm_adc_model (
    .clk_i(clk_i), .start_i(adc_start_o), .chan_i(adc_chan_o),
    .data_o(adc_data_i), .valid_o(adc_valid_i), .fault_o(diode_fault_i));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // Hang guard, well above four loop rounds
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic chk(input string nm, input logic [7:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
  endtask
  // Read data lands on the edge that takes the strobe
  task automatic rd(input logic [7:0] a, exp);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    chk("rdata", exp, reg_rdata_o);
  endtask
  task automatic wait_start(input logic [2:0] ch);
    int n;
    n = 0;
    @(negedge clk_i);
    while (!(adc_start_o === 1'b1 && adc_chan_o === ch) && n < 2000) begin
      @(negedge clk_i);
      n++;
    end
    // A loop that never reaches the channel must not pass quietly
    if (n >= 2000) begin
      error_cnt++;
      $display("ERROR adc_start channel %0d expected 1 seen 0", ch);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    rst_i = 1'b1;
    reg_addr_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_wdata_i = 8'h00;
    reg_rd_i = 1'b0;
    repeat (16) @(negedge clk_i);
    rst_i = 1'b0;
    chk("low_power", 8'h01, {7'h00, low_power_o});
    wr(8'h42, 8'hFF);
    rd(8'h42, 8'h00);
    rd(8'h10, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      wr(8'(8'h2B + 2 * i), hi[i]);
      wr(8'(8'h2C + 2 * i), lo[i]);
      rd(8'(8'h2B + 2 * i), hi[i]);
      rd(8'(8'h2C + 2 * i), lo[i]);
      i_mlm_adc_model.smp[i] = sv[i];
    end
    i_mlm_adc_model.fault_o = 1'b1;
    wr(8'h40, 8'h01);
    wait_start(3'h7);
    wait_start(3'h0);
    for (int i = 0; i < 8; i++)
      rd(8'(8'h20 + i), (i == 6) ? 8'hF5 : sv[i]);
    chk("irq", 8'h01, {7'h00, irq_o});
    chk("status1", 8'h08, status1_o);
    chk("status2", 8'h41, status2_o);
    rd(8'h41, 8'h08);
    chk("irq", 8'h00, {7'h00, irq_o});
    rd(8'h41, 8'h08);
    rd(8'h42, 8'h41);
    wait_start(3'h0);
    chk("irq", 8'h01, {7'h00, irq_o});
    $display("test first loop done");
    i_mlm_adc_model.dly = 12;
    i_mlm_adc_model.smp[3] = 8'h37;
    i_mlm_adc_model.fault_o = 1'b0;
    wait_start(3'h7);
    wait_start(3'h0);
    rd(8'h41, 8'h00);
    rd(8'h42, 8'h01);
    rd(8'h23, 8'h37);
    chk("status1", 8'h00, status1_o);
    $display("test slow converter done");
    wr(8'h40, 8'h00);
    repeat (40) @(negedge clk_i);
    chk("low_power", 8'h01, {7'h00, low_power_o});
    chk("status2", 8'h01, status2_o);
    rd(8'h27, 8'hE7);
    rd(8'h40, 8'h00);
    $display("test halt done");
    tally_and_finish();
  end
endmodule
